// ==== include/rms_pkg.sv ====
/*
  Constants for the reference monitor and switchover block.
  Assumes a 40 MHz system clock and word-indexed APB registers.
*/
package rms_pkg;
  // ==================================================
  // Timing
  localparam longint CLK_HZ = 40000000;
  localparam longint FS_PER_S = 64'd1000000000000000;
  localparam logic [47:0] SYS_PERIOD_FS = 48'(FS_PER_S / CLK_HZ);
  localparam longint MS_PER_S = 1000;
  localparam logic [15:0] CYC_PER_MS = 16'(CLK_HZ / MS_PER_S);
  // ==================================================
  // Register indices (byte address is four times)
  localparam logic [13:0] IDX_UPDATE = 14'h0005;
  localparam logic [13:0] IDX_FTW = 14'h0300;
  localparam logic [13:0] IDX_PWRDN = 14'h0600;
  localparam logic [13:0] IDX_FAMILY = 14'h0601;
  localparam logic [13:0] IDX_PRIO = 14'h0602;
  localparam logic [13:0] IDX_PROF = 14'h0700;
  localparam logic [13:0] PROF_STRIDE = 14'h0040;
  localparam logic [13:0] OFS_NOM_LO = 14'h0000;
  localparam logic [13:0] OFS_NOM_HI = 14'h0001;
  localparam logic [13:0] OFS_TIN = 14'h0002;
  localparam logic [13:0] OFS_TOUT = 14'h0003;
  localparam logic [13:0] OFS_TMO = 14'h0004;
  localparam logic [13:0] IDX_LOOP_MODE = 14'h0a01;
  localparam logic [13:0] IDX_MAN_VALID = 14'h0a0b;
  localparam logic [13:0] IDX_FORCE_INV = 14'h0a0d;
  localparam logic [13:0] IDX_STATUS = 14'h0d00;
  // ==================================================
  // Loop mode fields
  localparam int LM_HOLD = 0;
  localparam int LM_MODE_LO = 2;
  localparam int LM_FREE = 5;
  localparam int LM_USER = 6;
  localparam logic [2:0] SW_AUTO_REV = 3'h0;
  localparam logic [2:0] SW_AUTO_NREV = 3'h1;
  localparam logic [2:0] SW_MAN_FALL = 3'h2;
  localparam logic [2:0] SW_MAN_HOLD = 3'h3;
  localparam logic [2:0] SW_FULL_MAN = 3'h4;
  localparam int PRIO_HI = 4;
  // ==================================================
  // Reset values
  localparam logic [7:0] LOOP_MODE_RST = 8'h00;
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam logic [29:0] FTW_RST = 30'h00000000;
  localparam logic [39:0] NOM_RST = 40'h0000000000;
  localparam logic [19:0] TOL_RST = 20'h00000;
  localparam logic [15:0] TMO_RST = 16'h0000;
  localparam int AVG_SHIFT = 4;
  typedef enum logic [1:0] {ST_FREE, ST_LOCK, ST_HOLD} rms_loop_type;
endpackage

// ==== core/rms_switchover.sv ====
/*
  Reference period monitors, validation timers, overrides and the
  switchover state machine, with an APB register slave.
  Assumes reference inputs and the loop word synchronous to pclk.
*/
// The APB register port was left to the implementer.
`timescale 1ns/100ps
`default_nettype none
// Overview of operation
// - Monitors idle and report their references faulted until the system clock is stable.
// - Each reference period is measured and compared to a 40-bit fs nominal.
// - Tolerances are 20-bit reciprocals; larger value means tighter.
// - Faulted reference clears only within the inner tolerance.
// - Nonfaulted reference faults when beyond the outer tolerance.
// - Valid only after staying unfaulted for the whole timeout.
// - Timeout is 16 bits of milliseconds, up to 65535 ms.
// - Zero timeout disables auto validation; manual override validates.
// - Overrides force a reference valid or invalid.
// - Per-reference profile applies when that reference becomes active.
// - Mode field bits 4..2 of loop mode select five modes.
// - Automatic modes pick highest-priority valid; tie prefers first input.
// - Input position breaks ties only, never causes a switch.
// - Revertive mode moves to higher priority when valid; ignores user.
// - Non-revertive keeps current while valid; ignores user.
// - Manual fallback uses user reference, else best valid one.
// - Manual holdover uses user reference, else holdover, or free run before any lock.
// - Full manual keeps user reference regardless; no auto holdover.
// - User free run bit forces free run; holdover bit forces holdover, or free run before any lock.
// - Holdover output is an average of the recent loop word.
// - Loop mode bit 5 forces free run.
// - Settings apply only after writing one to update bit 0.
// - Power-down, logic family and priority live in input registers.
module rms_switchover (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [15:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic sysclk_stable,
  input wire logic [1:0] ref_in,
  input wire logic [29:0] loop_freq_word,
  output logic [29:0] freq_word,
  output logic active_ref,
  output logic ref_locked,
  output logic in_holdover,
  output logic in_free_run,
  output logic profile_apply,
  output logic status_event,
  output logic [1:0] ref_faulted,
  output logic [1:0] ref_valid
);
  // ==================================================
  // Register storage: shadow and active copies
  logic [7:0] mode_sh, mode, mval_sh, mval, finv_sh, finv;
  logic [7:0] pdn_sh, pdn, fam_sh, fam, pri_sh, pri;
  logic [29:0] ftw_sh, ftw, avg;
  logic [39:0] nom_sh [2];
  logic [39:0] nom [2];
  logic [19:0] tin_sh [2];
  logic [19:0] tin [2];
  logic [19:0] tout_sh [2];
  logic [19:0] tout [2];
  logic [15:0] tmo_sh [2];
  logic [15:0] tmo [2];
  logic apply, wr_en, setup, hit;
  logic [13:0] idx;
  logic [31:0] rd;
  logic [1:0] ref_prev, val;
  wire [1:0] flt, aval;
  rms_pkg::rms_loop_type state, next_state;
  logic act, next_act, hist;
  logic [5:0] stat_d;

  assign idx = paddr[15:2];
  assign setup = psel & ~penable;
  assign wr_en = psel & penable & pready & pwrite & hit;

  // ==================================================
  // APB slave: one wait-free access after setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      pready <= setup;
      pslverr <= setup & ~hit;
      prdata <= (setup & ~pwrite) ? rd : 32'h00000000;
    end
  end

  // Decode and read mux
  always_comb begin
    hit = 1'b1;
    rd = 32'h00000000;
    case (idx)
      rms_pkg::IDX_UPDATE: rd = 32'h00000000;
      rms_pkg::IDX_FTW: rd = {2'b00, ftw_sh};
      rms_pkg::IDX_PWRDN: rd = {24'h000000, pdn_sh};
      rms_pkg::IDX_FAMILY: rd = {24'h000000, fam_sh};
      rms_pkg::IDX_PRIO: rd = {24'h000000, pri_sh};
      rms_pkg::IDX_LOOP_MODE: rd = {24'h000000, mode_sh};
      rms_pkg::IDX_MAN_VALID: rd = {24'h000000, mval_sh};
      rms_pkg::IDX_FORCE_INV: rd = {24'h000000, finv_sh};
      rms_pkg::IDX_STATUS: rd = {25'h0000000, state, act, val, flt};
      default: hit = 1'b0;
    endcase
    for (int i = 0; i < 2; i++) begin
      if (idx == rms_pkg::IDX_PROF + 14'(i) * rms_pkg::PROF_STRIDE + rms_pkg::OFS_NOM_LO) begin
        rd = nom_sh[i][31:0];
        hit = 1'b1;
      end
      if (idx == rms_pkg::IDX_PROF + 14'(i) * rms_pkg::PROF_STRIDE + rms_pkg::OFS_NOM_HI) begin
        rd = {24'h000000, nom_sh[i][39:32]};
        hit = 1'b1;
      end
      if (idx == rms_pkg::IDX_PROF + 14'(i) * rms_pkg::PROF_STRIDE + rms_pkg::OFS_TIN) begin
        rd = {12'h000, tin_sh[i]};
        hit = 1'b1;
      end
      if (idx == rms_pkg::IDX_PROF + 14'(i) * rms_pkg::PROF_STRIDE + rms_pkg::OFS_TOUT) begin
        rd = {12'h000, tout_sh[i]};
        hit = 1'b1;
      end
      if (idx == rms_pkg::IDX_PROF + 14'(i) * rms_pkg::PROF_STRIDE + rms_pkg::OFS_TMO) begin
        rd = {16'h0000, tmo_sh[i]};
        hit = 1'b1;
      end
    end
  end

  // Shadow register writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_sh <= rms_pkg::LOOP_MODE_RST;
      mval_sh <= rms_pkg::BYTE_RST;
      finv_sh <= rms_pkg::BYTE_RST;
      pdn_sh <= rms_pkg::BYTE_RST;
      fam_sh <= rms_pkg::BYTE_RST;
      pri_sh <= rms_pkg::BYTE_RST;
      ftw_sh <= rms_pkg::FTW_RST;
      for (int i = 0; i < 2; i++) begin
        nom_sh[i] <= rms_pkg::NOM_RST;
        tin_sh[i] <= rms_pkg::TOL_RST;
        tout_sh[i] <= rms_pkg::TOL_RST;
        tmo_sh[i] <= rms_pkg::TMO_RST;
      end
    end else if (wr_en) begin
      if (idx == rms_pkg::IDX_LOOP_MODE) mode_sh <= pwdata[7:0];
      if (idx == rms_pkg::IDX_MAN_VALID) mval_sh <= pwdata[7:0];
      if (idx == rms_pkg::IDX_FORCE_INV) finv_sh <= pwdata[7:0];
      if (idx == rms_pkg::IDX_PWRDN) pdn_sh <= pwdata[7:0];
      if (idx == rms_pkg::IDX_FAMILY) fam_sh <= pwdata[7:0];
      if (idx == rms_pkg::IDX_PRIO) pri_sh <= pwdata[7:0];
      if (idx == rms_pkg::IDX_FTW) ftw_sh <= pwdata[29:0];
      for (int i = 0; i < 2; i++) begin
        if (idx == rms_pkg::IDX_PROF + 14'(i) * rms_pkg::PROF_STRIDE + rms_pkg::OFS_NOM_LO)
          nom_sh[i][31:0] <= pwdata;
        if (idx == rms_pkg::IDX_PROF + 14'(i) * rms_pkg::PROF_STRIDE + rms_pkg::OFS_NOM_HI)
          nom_sh[i][39:32] <= pwdata[7:0];
        if (idx == rms_pkg::IDX_PROF + 14'(i) * rms_pkg::PROF_STRIDE + rms_pkg::OFS_TIN)
          tin_sh[i] <= pwdata[19:0];
        if (idx == rms_pkg::IDX_PROF + 14'(i) * rms_pkg::PROF_STRIDE + rms_pkg::OFS_TOUT)
          tout_sh[i] <= pwdata[19:0];
        if (idx == rms_pkg::IDX_PROF + 14'(i) * rms_pkg::PROF_STRIDE + rms_pkg::OFS_TMO)
          tmo_sh[i] <= pwdata[15:0];
      end
    end
  end

  // Update strobe copies shadow to active set
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      apply <= 1'b0;
      mode <= rms_pkg::LOOP_MODE_RST;
      mval <= rms_pkg::BYTE_RST;
      finv <= rms_pkg::BYTE_RST;
      pdn <= rms_pkg::BYTE_RST;
      fam <= rms_pkg::BYTE_RST;
      pri <= rms_pkg::BYTE_RST;
      ftw <= rms_pkg::FTW_RST;
      for (int i = 0; i < 2; i++) begin
        nom[i] <= rms_pkg::NOM_RST;
        tin[i] <= rms_pkg::TOL_RST;
        tout[i] <= rms_pkg::TOL_RST;
        tmo[i] <= rms_pkg::TMO_RST;
      end
    end else begin
      apply <= wr_en & (idx == rms_pkg::IDX_UPDATE) & pwdata[0];
      if (apply) begin
        mode <= mode_sh;
        mval <= mval_sh;
        finv <= finv_sh;
        pdn <= pdn_sh;
        fam <= fam_sh;
        pri <= pri_sh;
        ftw <= ftw_sh;
        nom <= nom_sh;
        tin <= tin_sh;
        tout <= tout_sh;
        tmo <= tmo_sh;
      end
    end
  end

  // ==================================================
  // Per-reference period monitor and validation timer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) ref_prev <= 2'b00;
    else ref_prev <= ref_in;
  end

  for (genvar g = 0; g < 2; g++) begin : mon
    logic [23:0] cnt;
    logic [15:0] cyc, ms;
    logic f, av, primed, run, edge_seen, chk;
    logic [47:0] meas, dev;
    logic pass_in, fail_out;

    assign run = sysclk_stable & ~pdn[g];
    assign edge_seen = ref_in[g] & ~ref_prev[g];
    assign meas = 48'({24'h000000, cnt} * rms_pkg::SYS_PERIOD_FS);
    assign dev = (meas > {8'h00, nom[g]}) ? meas - {8'h00, nom[g]} : {8'h00, nom[g]} - meas;
    // Deviation within nominal over reciprocal tolerance
    assign pass_in = ({20'h00000, dev} * {48'h0, tin[g]}) <= {28'h0, nom[g]};
    assign fail_out = ({20'h00000, dev} * {48'h0, tout[g]}) > {28'h0, nom[g]};
    // Late check: missing edges only grow the deviation
    assign chk = (edge_seen & primed) | (meas > {8'h00, nom[g]});
    assign flt[g] = f;
    assign aval[g] = av;

    // Period counter
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        cnt <= 24'h000000;
        primed <= 1'b0;
      end else if (!run) begin
        cnt <= 24'h000000;
        primed <= 1'b0;
      end else if (edge_seen) begin
        cnt <= 24'h000001;
        primed <= 1'b1;
      end else if (cnt != 24'hffffff) begin
        cnt <= cnt + 24'h000001;
      end
    end

    // Fault decision with hysteresis
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) f <= 1'b1;
      else if (!run) f <= 1'b1;
      else if (chk && f && edge_seen && primed) f <= ~pass_in;
      else if (chk && !f) f <= fail_out;
    end

    // Millisecond validation timer
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        cyc <= 16'h0000;
        ms <= 16'h0000;
        av <= 1'b0;
      end else if (f || tmo[g] == 16'h0000) begin
        cyc <= 16'h0000;
        ms <= 16'h0000;
        av <= 1'b0;
      end else if (!av) begin
        av <= (ms == tmo[g]);
        if (cyc == rms_pkg::CYC_PER_MS - 16'h0001) begin
          cyc <= 16'h0000;
          ms <= ms + 16'h0001;
        end else begin
          cyc <= cyc + 16'h0001;
        end
      end
    end

    a_mon_idle: assert property (@(posedge pclk) disable iff (!presetn)
      !run |=> f) else $error("monitor not idle");
    a_fault_rise: assert property (@(posedge pclk) disable iff (!presetn)
      run && !f && chk && fail_out |=> f) else $error("fault missed");
    a_fault_hold: assert property (@(posedge pclk) disable iff (!presetn)
      run && f && !(edge_seen && primed && pass_in) |=> f) else $error("early clear");
    a_timer_zero: assert property (@(posedge pclk) disable iff (!presetn)
      tmo[g] == 16'h0000 |=> !av) else $error("auto valid at zero");
    a_valid_time: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(av) |-> $past(!f) && $past(ms) == tmo[g]) else $error("valid too soon");
  end

  // Overrides on the monitor result
  assign val = (aval | mval[1:0]) & ~finv[1:0];

  // ==================================================
  // Switchover selection
  logic [2:0] sw, pr0, pr1;
  logic best, usr, any;
  assign sw = mode[rms_pkg::LM_MODE_LO +: 3];
  assign pr0 = pri[2:0];
  assign pr1 = pri[rms_pkg::PRIO_HI +: 3];
  assign usr = mode[rms_pkg::LM_USER];
  assign any = |val;
  // Lower value wins; tie goes to first input
  assign best = ~(val[0] & (~val[1] | pr0 <= pr1));

  always_comb begin
    next_state = state;
    next_act = act;
    if (!sysclk_stable) begin
      next_state = rms_pkg::ST_FREE;
    end else if (mode[rms_pkg::LM_FREE]) begin
      next_state = rms_pkg::ST_FREE;
    end else if (mode[rms_pkg::LM_HOLD]) begin
      next_state = hist ? rms_pkg::ST_HOLD : rms_pkg::ST_FREE;
    end else begin
      case (sw)
        rms_pkg::SW_AUTO_REV: begin
          if (!any) next_state = hist ? rms_pkg::ST_HOLD : rms_pkg::ST_FREE;
          else if (state != rms_pkg::ST_LOCK || !val[act]
                   || (best ? pr1 : pr0) < (act ? pr1 : pr0)) begin
            next_state = rms_pkg::ST_LOCK;
            next_act = best;
          end
        end
        rms_pkg::SW_AUTO_NREV: begin
          if (state == rms_pkg::ST_LOCK && val[act]) next_state = rms_pkg::ST_LOCK;
          else if (any) begin
            next_state = rms_pkg::ST_LOCK;
            next_act = best;
          end else next_state = hist ? rms_pkg::ST_HOLD : rms_pkg::ST_FREE;
        end
        rms_pkg::SW_MAN_FALL: begin
          next_state = rms_pkg::ST_LOCK;
          if (val[usr]) next_act = usr;
          else if (any) next_act = best;
          else next_state = hist ? rms_pkg::ST_HOLD : rms_pkg::ST_FREE;
        end
        rms_pkg::SW_MAN_HOLD: begin
          if (val[usr]) begin
            next_state = rms_pkg::ST_LOCK;
            next_act = usr;
          end else next_state = hist ? rms_pkg::ST_HOLD : rms_pkg::ST_FREE;
        end
        default: begin
          next_state = rms_pkg::ST_LOCK;
          next_act = usr;
        end
      endcase
    end
  end

  // Signed step toward the loop word; small rises step by one so the average settles exactly
  logic signed [31:0] avg_diff, avg_step;
  assign avg_diff = $signed(32'(loop_freq_word)) - $signed(32'(avg));
  assign avg_step = ((avg_diff >>> rms_pkg::AVG_SHIFT) == 32'sh0 && avg_diff > 32'sh0)
                    ? 32'sh1 : (avg_diff >>> rms_pkg::AVG_SHIFT);

  // Loop state, history and outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= rms_pkg::ST_FREE;
      act <= 1'b0;
      hist <= 1'b0;
      avg <= rms_pkg::FTW_RST;
      freq_word <= rms_pkg::FTW_RST;
      active_ref <= 1'b0;
      ref_locked <= 1'b0;
      in_holdover <= 1'b0;
      in_free_run <= 1'b1;
      profile_apply <= 1'b0;
    end else begin
      state <= next_state;
      act <= next_act;
      if (state == rms_pkg::ST_LOCK) begin
        hist <= 1'b1;
        avg <= avg + avg_step[29:0];
      end
      case (next_state)
        rms_pkg::ST_LOCK: freq_word <= loop_freq_word;
        rms_pkg::ST_HOLD: freq_word <= avg;
        default: freq_word <= ftw;
      endcase
      active_ref <= next_act;
      ref_locked <= next_state == rms_pkg::ST_LOCK;
      in_holdover <= next_state == rms_pkg::ST_HOLD;
      in_free_run <= next_state == rms_pkg::ST_FREE;
      // Profile of the newly active reference goes to the loop
      profile_apply <= next_state == rms_pkg::ST_LOCK
                       && (state != rms_pkg::ST_LOCK || next_act != act);
    end
  end

  // Status flags and change event
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat_d <= 6'h03;
      status_event <= 1'b0;
      ref_faulted <= 2'b11;
      ref_valid <= 2'b00;
    end else begin
      stat_d <= {ref_locked, active_ref, val, flt};
      status_event <= {ref_locked, active_ref, val, flt} != stat_d;
      ref_faulted <= flt;
      ref_valid <= val;
    end
  end

  sequence s_setup;
    psel && !penable;
  endsequence
  a_apb_answer: assert property (@(posedge pclk) disable iff (!presetn)
    s_setup |=> pready ##1 !pready) else $error("apb answer late");
  a_update_only: assert property (@(posedge pclk) disable iff (!presetn)
    mode != $past(mode) |-> $past(apply)) else $error("mode without update");
  a_user_free: assert property (@(posedge pclk) disable iff (!presetn)
    mode[rms_pkg::LM_FREE] |=> in_free_run) else $error("free run not forced");
  a_full_manual: assert property (@(posedge pclk) disable iff (!presetn)
    sysclk_stable && mode[5] == 1'b0 && mode[0] == 1'b0 && sw == rms_pkg::SW_FULL_MAN
    |=> state == rms_pkg::ST_LOCK && act == $past(usr)) else $error("manual lost");
  a_force_inv: assert property (@(posedge pclk) disable iff (!presetn)
    finv[0] |=> !ref_valid[0]) else $error("forced invalid shows valid");
endmodule
`default_nettype wire

// ==== verif/rms_ref_source.sv ====
/*
  Behavioural reference clock source standing in for one input.
  Assumes period in pclk cycles; zero stops the clock low.
*/
`timescale 1ns/100ps
`default_nettype none
module rms_ref_source (
  input wire logic pclk,
  input wire logic [7:0] period,
  output logic ref_out
);
  int cnt;
  // ==================================================
  // Clock generation
  // Idle level before the first edge
  initial begin
    cnt = 0;
    ref_out = 1'b0;
  end
  // One rising edge per period, high for half of it
  always @(posedge pclk) begin
    if (period == 8'h00) begin
      cnt <= 0;
      ref_out <= 1'b0;
    end else begin
      cnt <= (cnt + 1 >= int'(period)) ? 0 : cnt + 1;
      ref_out <= (cnt < int'(period) / 2);
    end
  end
endmodule
`default_nettype wire

// ==== verif/tb_reference_monitor_switchover.sv ====
/*
  Self-checking bench for the reference monitor and switchover block.
  Assumes the package constants and two behavioural reference sources.
*/
`timescale 1ns/100ps
`default_nettype none
`define CHECK(got, exp) begin tests_run++; if ((got) !== (exp)) begin n_mismatch++; \
  $display("ERROR t=%0t got %h expected %h", $time, (got), (exp)); end end
module tb_reference_monitor_switchover;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, sysclk_stable;
  logic [15:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic [29:0] loop_freq_word, freq_word;
  logic active_ref, ref_locked, in_holdover, in_free_run, profile_apply, status_event, e;
  logic [1:0] ref_faulted, ref_valid;
  wire [1:0] ref_in;
  logic [7:0] per0, per1, obs;
  logic [13:0] base;
  logic [2:0] codes [2] = '{3'h4, 3'h7};
  int n_mismatch = 0;
  int tests_run = 0;
  int n_apply = 0;
  int n_event = 0;
  // ==================================================
  // Design, sources and observation
  rms_switchover u_rms_switchover (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sysclk_stable(sysclk_stable), .ref_in(ref_in),
    .loop_freq_word(loop_freq_word), .freq_word(freq_word), .active_ref(active_ref),
    .ref_locked(ref_locked), .in_holdover(in_holdover), .in_free_run(in_free_run),
    .profile_apply(profile_apply), .status_event(status_event),
    .ref_faulted(ref_faulted), .ref_valid(ref_valid));
  rms_ref_source u_src_first (.pclk(pclk), .period(per0), .ref_out(ref_in[0]));
  rms_ref_source u_src_second (.pclk(pclk), .period(per1), .ref_out(ref_in[1]));
  // Flags, validity and loop state in one vector
  assign obs = {ref_faulted, ref_valid, active_ref, ref_locked, in_holdover, in_free_run};
  // Pulse counters
  always @(posedge pclk) begin
    if (profile_apply === 1'b1) n_apply++;
    if (status_event === 1'b1) n_event++;
  end
  // Clock
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  // ==================================================
  // Tasks
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // One APB transfer, held until pready is sampled high
  task automatic apb(input logic wr, input logic [13:0] idx, input logic [31:0] wd);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {idx, 2'h0};
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) begin
      n_mismatch++;
      report_and_stop;
    end
  endtask
  task automatic wr(input logic [13:0] idx, input logic [31:0] d);
    apb(1'b1, idx, d);
  endtask
  task automatic upd;
    wr(rms_pkg::IDX_UPDATE, 32'h00000001);
  endtask
  // Bounded wait for masked outputs
  task automatic wait_obs(input logic [7:0] m, input logic [7:0] x, input int bound);
    int n;
    n = 0;
    while ((obs & m) !== x && n < bound) begin
      @(posedge pclk);
      n++;
    end
    `CHECK(obs & m, x)
    if ((obs & m) !== x) report_and_stop;
  endtask
  function automatic logic [31:0] lm(input logic [2:0] md, input logic u);
    return {25'h0, u, 1'b0, md, 2'h0};
  endfunction
  // ==================================================
  // Main sequence
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 16'h0000;
    pwdata = 32'h00000000;
    sysclk_stable = 1'b0;
    loop_freq_word = 30'h01234567;
    per0 = 8'd20;
    per1 = 8'd21;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    wait_obs(8'hff, 8'hc1, 1);
    apb(1'b0, rms_pkg::IDX_LOOP_MODE, 32'h0);
    `CHECK(r, {24'h0, rms_pkg::LOOP_MODE_RST})
    apb(1'b0, 14'h0001, 32'h0);
    `CHECK({e, r}, 33'h100000000)
    for (int g = 0; g < 2; g++) begin
      base = rms_pkg::IDX_PROF + 14'(g) * rms_pkg::PROF_STRIDE;
      wr(base + rms_pkg::OFS_NOM_LO, 32'h1dcd6500);
      wr(base + rms_pkg::OFS_NOM_HI, 32'h00000000);
      wr(base + rms_pkg::OFS_TIN, 32'h00000032);
      wr(base + rms_pkg::OFS_TOUT, 32'h0000000a);
      wr(base + rms_pkg::OFS_TMO, 32'h00000001);
    end
    wr(rms_pkg::IDX_PRIO, 32'h00000013);
    wr(rms_pkg::IDX_FTW, 32'h0abcdef0);
    upd();
    repeat (300) @(posedge pclk);
    wait_obs(8'hc1, 8'hc1, 1);
    $display("test idle monitors done");
    sysclk_stable <= 1'b1;
    wait_obs(8'hc0, 8'h80, 200);
    repeat (200) @(posedge pclk);
    wait_obs(8'hc0, 8'h80, 1);
    per1 <= 8'd20;
    repeat (39000) @(posedge pclk);
    wait_obs(8'h30, 8'h00, 1);
    wait_obs(8'h3f, 8'h14, 2000);
    wait_obs(8'h3f, 8'h3c, 1000);
    // Let the pulse counters take the last edge
    repeat (2) @(posedge pclk);
    `CHECK(n_apply, 2)
    `CHECK(n_event > 0, 1'b1)
    $display("test validation done");
    per1 <= 8'd21;
    repeat (300) @(posedge pclk);
    wait_obs(8'hc0, 8'h00, 1);
    per1 <= 8'd24;
    wait_obs(8'hf8, 8'h90, 300);
    per1 <= 8'd20;
    $display("test fault done");
    wr(rms_pkg::IDX_MAN_VALID, 32'h00000002);
    upd();
    wait_obs(8'h3c, 8'h3c, 50);
    apb(1'b0, rms_pkg::IDX_MAN_VALID, 32'h0);
    `CHECK(r, 32'h00000002)
    wr(rms_pkg::IDX_PRIO, 32'h00000022);
    upd();
    repeat (50) @(posedge pclk);
    wait_obs(8'h0f, 8'h0c, 1);
    wr(rms_pkg::IDX_LOOP_MODE, lm(rms_pkg::SW_AUTO_NREV, 1'b0));
    wr(rms_pkg::IDX_FORCE_INV, 32'h00000002);
    upd();
    wait_obs(8'h0f, 8'h04, 50);
    wr(rms_pkg::IDX_FORCE_INV, 32'h00000000);
    wr(rms_pkg::IDX_PRIO, 32'h00000013);
    upd();
    repeat (50) @(posedge pclk);
    wait_obs(8'h3f, 8'h34, 1);
    wr(rms_pkg::IDX_LOOP_MODE, lm(rms_pkg::SW_MAN_FALL, 1'b0));
    upd();
    repeat (20) @(posedge pclk);
    wait_obs(8'h0f, 8'h04, 1);
    wr(rms_pkg::IDX_FORCE_INV, 32'h00000001);
    upd();
    wait_obs(8'h0f, 8'h0c, 50);
    wr(rms_pkg::IDX_LOOP_MODE, lm(rms_pkg::SW_MAN_HOLD, 1'b1));
    wr(rms_pkg::IDX_FORCE_INV, 32'h00000002);
    upd();
    wait_obs(8'h07, 8'h02, 50);
    repeat (5) @(posedge pclk);
    `CHECK(freq_word, 30'h01234567)
    foreach (codes[i]) begin
      wr(rms_pkg::IDX_LOOP_MODE, lm(codes[i], 1'b1));
      upd();
      wait_obs(8'h0f, 8'h0c, 50);
    end
    $display("test modes done");
    wr(rms_pkg::IDX_LOOP_MODE, lm(rms_pkg::SW_FULL_MAN, 1'b1) | 32'h00000020);
    repeat (20) @(posedge pclk);
    wait_obs(8'h0f, 8'h0c, 1);
    upd();
    wait_obs(8'h07, 8'h01, 50);
    repeat (5) @(posedge pclk);
    `CHECK(freq_word, 30'h0abcdef0)
    wr(rms_pkg::IDX_LOOP_MODE, lm(rms_pkg::SW_FULL_MAN, 1'b1) | 32'h00000001);
    upd();
    wait_obs(8'h07, 8'h02, 50);
    sysclk_stable <= 1'b0;
    wait_obs(8'h07, 8'h01, 50);
    $display("test forced states done");
    report_and_stop;
  end
endmodule
`default_nettype wire
